// ---- rtl/swfs_pkg.sv ----
package swfs_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  // nominal watchdog periods, ms
  localparam int unsigned WD_MS_00 = 620;
  localparam int unsigned WD_MS_01 = 310;
  localparam int unsigned WD_MS_10 = 2500;
  localparam int unsigned WD_MS_11 = 1250;
  localparam int unsigned WD_CYC_00 = WD_MS_00 * CYC_PER_MS;
  localparam int unsigned WD_CYC_01 = WD_MS_01 * CYC_PER_MS;
  localparam int unsigned WD_CYC_10 = WD_MS_10 * CYC_PER_MS;
  localparam int unsigned WD_CYC_11 = WD_MS_11 * CYC_PER_MS;
  // nominal over-current blanking windows, us
  localparam int unsigned OCH_US = 10;
  localparam int unsigned OCL_US_00 = 155_000;
  localparam int unsigned OCL_US_01 = 10_000;
  localparam int unsigned OCL_US_10 = 1200;
  localparam int unsigned OCL_US_11 = 150;
  localparam int unsigned OCH_CYC = OCH_US * CYC_PER_US;
  localparam int unsigned OCL_CYC_00 = OCL_US_00 * CYC_PER_US;
  localparam int unsigned OCL_CYC_01 = OCL_US_01 * CYC_PER_US;
  localparam int unsigned OCL_CYC_10 = OCL_US_10 * CYC_PER_US;
  localparam int unsigned OCL_CYC_11 = OCL_US_11 * CYC_PER_US;
  localparam int unsigned CNT_W = 32;
  // fault identity bit positions
  localparam int unsigned FID_OCH = 0;
  localparam int unsigned FID_OCL = 1;
  localparam int unsigned FID_EXT = 2;
  localparam int unsigned EXT_FAULTS = 4;
  typedef enum logic [3:0] {
    SWFS_OFF     = 4'b0001,
    SWFS_BLANK_H = 4'b0010,
    SWFS_BLANK_L = 4'b0100,
    SWFS_STEADY  = 4'b1000
  } swfs_oc_st_t;
endpackage : swfs_pkg

// ---- rtl/swfs_ctrl.sv ----
// Overview of operation
// - The watchdog only runs while the wake input is high.
// - While the reset pin is low all configuration and fault state returns to its defaults; here fail-safe holds while wake is high and new faults still latch.
// - A low reset pin puts the device into sleep.
// - A rising edge on the reset pin starts the watchdog count.
// - The direct input drives the output when selected as the control source.
// - Any fault pulls the open-drain fault flag low, otherwise the flag is released.
// - Individual fault identities go only to the serial side; the flag is a combined indication.
// - After a watchdog timeout the output is driven on or off per the fail-safe select input.
// - A grounded fail-safe select input disables the watchdog and fail-safe operation.
// - In the high blanking window only the high threshold trips; in the low windows the low one also trips.
// - A two-bit field selects a watchdog period of 620, 310, 2500 or 1250 ms.
// - With wake and reset both low the device sleeps with power output and fail-safe off; new faults still latch and drive the fault flag.
// - Loss of the logic supply resets all configuration state while limited logic stays alive.
`timescale 1ns/1ps
module swfs_ctrl #(
  parameter int unsigned N_EXT = swfs_pkg::EXT_FAULTS,
  parameter int unsigned WD_CYC0 = swfs_pkg::WD_CYC_00,
  parameter int unsigned WD_CYC1 = swfs_pkg::WD_CYC_01,
  parameter int unsigned WD_CYC2 = swfs_pkg::WD_CYC_10,
  parameter int unsigned WD_CYC3 = swfs_pkg::WD_CYC_11,
  parameter int unsigned OCL_CYC0 = swfs_pkg::OCL_CYC_00,
  parameter int unsigned OCL_CYC1 = swfs_pkg::OCL_CYC_01,
  parameter int unsigned OCL_CYC2 = swfs_pkg::OCL_CYC_10,
  parameter int unsigned OCL_CYC3 = swfs_pkg::OCL_CYC_11
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // control pins
  input wire logic rst_pin_n_i,
  input wire logic wake_i,
  input wire logic direct_in_i,
  input wire logic vdd_lost_i,
  // fail-safe select sensing
  input wire logic failsafe_select_input_gnd_i,
  input wire logic failsafe_select_input_on_i,
  // serial-side configuration and events
  input wire logic [1:0] watchdog_period_sel_i,
  input wire logic [1:0] low_overcurrent_blank_sel_i,
  input wire logic direct_in_sel_i,
  input wire logic serial_out_cmd_i,
  input wire logic frame_ok_i,
  // analog comparators and other faults
  input wire logic oc_high_i,
  input wire logic oc_low_i,
  input wire logic [N_EXT-1:0] ext_fault_i,
  // outputs
  output logic power_out_o,
  output logic sleep_o,
  output logic failsafe_o,
  output logic watchdog_timeout_evt_o,
  output logic fault_flag_n_o,
  output logic fault_flag_oe_o,
  output logic [N_EXT+1:0] fault_id_o
);
  import swfs_pkg::*;

  function automatic logic [CNT_W-1:0] sel4(input logic [1:0] s, input int unsigned a, input int unsigned b,
                                            input int unsigned c, input int unsigned d);
    unique case (s)
      2'h0: sel4 = CNT_W'(a);
      2'h1: sel4 = CNT_W'(b);
      2'h2: sel4 = CNT_W'(c);
      default: sel4 = CNT_W'(d);
    endcase
  endfunction : sel4

  logic rst_prev_ff;
  logic wd_run_ff;
  logic [CNT_W-1:0] wd_cnt_ff;
  logic failsafe_ff;
  logic evt_ff;
  logic power_ff;
  logic sleep_ff;
  logic flag_oe_ff;
  logic flag_n_ff;
  logic [N_EXT+1:0] fault_id_ff;
  swfs_oc_st_t oc_st_ff;
  logic [CNT_W-1:0] oc_cnt_ff;

  logic init_now;
  logic both_low;
  logic wd_active;
  logic wd_hit;
  logic [CNT_W-1:0] wd_lim;
  logic [CNT_W-1:0] ocl_lim;
  logic trip_h;
  logic trip_l;
  logic [N_EXT+1:0] fault_set;

  assign init_now = !rst_pin_n_i || vdd_lost_i;
  assign both_low = !rst_pin_n_i && !wake_i;
  assign wd_lim = sel4(watchdog_period_sel_i, WD_CYC0, WD_CYC1, WD_CYC2, WD_CYC3);
  assign ocl_lim = sel4(low_overcurrent_blank_sel_i, OCL_CYC0, OCL_CYC1, OCL_CYC2, OCL_CYC3);
  assign wd_active = wake_i && !failsafe_select_input_gnd_i && wd_run_ff && !failsafe_ff && !init_now;
  assign wd_hit = wd_active && !frame_ok_i && (wd_cnt_ff == wd_lim - CNT_W'(1));
  assign trip_h = oc_high_i && (oc_st_ff != SWFS_OFF);
  assign trip_l = oc_low_i && (oc_st_ff == SWFS_BLANK_L || oc_st_ff == SWFS_STEADY);
  assign fault_set = {ext_fault_i, trip_l, trip_h};

  // watchdog
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_prev_ff <= 1'b0;
      wd_run_ff <= 1'b0;
      wd_cnt_ff <= '0;
      evt_ff <= 1'b0;
    end else if (ce_i) begin
      rst_prev_ff <= rst_pin_n_i;
      evt_ff <= wd_hit;
      if (init_now) begin
        wd_run_ff <= 1'b0;
        wd_cnt_ff <= '0;
      end else if (!rst_prev_ff) begin
        wd_run_ff <= 1'b1;
        wd_cnt_ff <= '0;
      end else if (frame_ok_i || wd_hit) begin
        wd_cnt_ff <= '0;
      end else if (wd_active) begin
        wd_cnt_ff <= wd_cnt_ff + CNT_W'(1);
      end
    end
  end

  // fail-safe mode; exit by the host wins over a same-cycle timeout
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      failsafe_ff <= 1'b0;
    end else if (ce_i) begin
      if (failsafe_select_input_gnd_i || both_low) begin
        failsafe_ff <= 1'b0;
      end else if (wd_hit) begin
        failsafe_ff <= 1'b1;
      end
    end
  end

  // power output and sleep
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_ff <= 1'b0;
      sleep_ff <= 1'b1;
    end else if (ce_i) begin
      sleep_ff <= !rst_pin_n_i;
      if (both_low || vdd_lost_i) begin
        power_ff <= 1'b0;
      end else if (failsafe_ff) begin
        power_ff <= failsafe_select_input_on_i;
      end else if (!rst_pin_n_i || (|fault_id_ff)) begin
        power_ff <= 1'b0;
      end else begin
        power_ff <= direct_in_sel_i ? direct_in_i : serial_out_cmd_i;
      end
    end
  end

  // over-current blanking phases
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oc_st_ff <= SWFS_OFF;
      oc_cnt_ff <= '0;
    end else if (ce_i) begin
      if (!power_ff) begin
        oc_st_ff <= SWFS_OFF;
        oc_cnt_ff <= '0;
      end else begin
        unique case (oc_st_ff)
          SWFS_OFF: begin
            oc_st_ff <= SWFS_BLANK_H;
            oc_cnt_ff <= '0;
          end
          SWFS_BLANK_H: begin
            if (oc_cnt_ff == CNT_W'(OCH_CYC - 1)) begin
              oc_st_ff <= SWFS_BLANK_L;
              oc_cnt_ff <= '0;
            end else begin
              oc_cnt_ff <= oc_cnt_ff + CNT_W'(1);
            end
          end
          SWFS_BLANK_L: begin
            if (oc_cnt_ff == ocl_lim - CNT_W'(1)) begin
              oc_st_ff <= SWFS_STEADY;
              oc_cnt_ff <= '0;
            end else begin
              oc_cnt_ff <= oc_cnt_ff + CNT_W'(1);
            end
          end
          SWFS_STEADY: oc_cnt_ff <= '0;
        endcase
      end
    end
  end

  // fault identity and combined flag; a new fault wins over the clear
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_id_ff <= '0;
      flag_oe_ff <= 1'b0;
      flag_n_ff <= 1'b1;
    end else if (ce_i) begin
      fault_id_ff <= (init_now ? '0 : fault_id_ff) | fault_set;
      flag_oe_ff <= |fault_id_ff;
      flag_n_ff <= !(|fault_id_ff);
    end
  end

  assign power_out_o = power_ff;
  assign sleep_o = sleep_ff;
  assign failsafe_o = failsafe_ff;
  assign watchdog_timeout_evt_o = evt_ff;
  assign fault_flag_oe_o = flag_oe_ff;
  assign fault_flag_n_o = flag_n_ff;
  assign fault_id_o = fault_id_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_wd_last;
    ce_i && wd_active && !frame_ok_i && wd_cnt_ff == wd_lim - CNT_W'(1);
  endsequence
  sequence s_fs_entered;
    watchdog_timeout_evt_o && failsafe_ff;
  endsequence

  AST_WD_NEEDS_WAKE: assert property (ce_i && !wake_i |=> !watchdog_timeout_evt_o)
    else $error("timeout without wake");
  AST_RST_CLEARS: assert property (ce_i && !rst_pin_n_i && ext_fault_i == '0 && !oc_high_i && !oc_low_i
    |=> fault_id_ff == '0 && !wd_run_ff)
    else $error("reset did not clear state");
  AST_SLEEP_ON_RST: assert property (ce_i && !rst_pin_n_i |=> sleep_o)
    else $error("no sleep on reset");
  AST_WD_START: assert property (ce_i && rst_pin_n_i && !rst_prev_ff && !vdd_lost_i
    |=> wd_run_ff && wd_cnt_ff == '0)
    else $error("watchdog not started");
  AST_DIRECT_IN: assert property (ce_i && rst_pin_n_i && !vdd_lost_i && !failsafe_ff && fault_id_ff == '0
    && direct_in_sel_i |=> power_out_o == $past(direct_in_i))
    else $error("direct input ignored");
  AST_FLAG: assert property (ce_i |=> fault_flag_oe_o == $past(|fault_id_ff) && fault_flag_n_o != fault_flag_oe_o)
    else $error("fault flag mismatch");
  AST_FS_DRIVE: assert property (ce_i && failsafe_ff && !both_low && !vdd_lost_i
    |=> power_out_o == $past(failsafe_select_input_on_i))
    else $error("fail-safe output wrong");
  AST_FSI_GND: assert property (ce_i && failsafe_select_input_gnd_i |=> !failsafe_ff && !watchdog_timeout_evt_o)
    else $error("grounded select did not disable");
  AST_BLANK_H: assert property (ce_i && oc_st_ff == SWFS_BLANK_H && !init_now
    |=> fault_id_ff[FID_OCL] == $past(fault_id_ff[FID_OCL]))
    else $error("low threshold tripped in high window");
  AST_SLEEP_OFF: assert property (ce_i && both_low |=> !power_out_o && !failsafe_ff)
    else $error("outputs on in sleep");
  AST_TIMEOUT: assert property (s_wd_last and (!failsafe_select_input_gnd_i && !both_low) |=> s_fs_entered)
    else $error("timeout not declared");
endmodule : swfs_ctrl

// ---- test/swfs_host.sv ----
`timescale 1ns/1ps
module swfs_host (
  // supply state and bench requests
  input wire logic supply_ok_i,
  input wire logic rst_req_i,
  input wire logic kick_i,
  // pins towards the switch
  output logic rst_pin_n_o,
  output logic frame_ok_o
);
  // reset pin stays low until the logic supply is good
  assign rst_pin_n_o = supply_ok_i & rst_req_i;
  // good frame held high for as long as the bench kick is high
  assign frame_ok_o = kick_i;
endmodule : swfs_host

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import swfs_pkg::*;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
  localparam int unsigned WDC [4] = '{60, 50, 90, 70};
  logic clock_i, sys_rst_i, supply_ok, rst_req, kick, rst_pin_n, frame_ok, ce;
  logic wake_i, direct_in_i, vdd_lost_i, fs_gnd, fs_on, din_sel, ser_cmd, oc_high, oc_low;
  logic [1:0] wd_sel, ocl_sel;
  logic [3:0] ext_fault;
  logic power_out_o, sleep_o, failsafe_o, watchdog_timeout_evt_o, fault_flag_n_o, fault_flag_oe_o;
  logic [5:0] fault_id_o;
  int n_errors = 0, checked = 0, n_evt = 0, cyc_cnt = 0, n;
  swfs_host swfs_host_i (.supply_ok_i(supply_ok), .rst_req_i(rst_req), .kick_i(kick),
    .rst_pin_n_o(rst_pin_n), .frame_ok_o(frame_ok));
  swfs_ctrl #(.WD_CYC0(WDC[0]), .WD_CYC1(WDC[1]), .WD_CYC2(WDC[2]), .WD_CYC3(WDC[3]),
    .OCL_CYC0(20), .OCL_CYC1(15), .OCL_CYC2(30), .OCL_CYC3(40)) swfs_ctrl_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .rst_pin_n_i(rst_pin_n), .wake_i(wake_i),
    .direct_in_i(direct_in_i), .vdd_lost_i(vdd_lost_i), .failsafe_select_input_gnd_i(fs_gnd),
    .failsafe_select_input_on_i(fs_on), .watchdog_period_sel_i(wd_sel),
    .low_overcurrent_blank_sel_i(ocl_sel), .direct_in_sel_i(din_sel), .serial_out_cmd_i(ser_cmd),
    .frame_ok_i(frame_ok), .oc_high_i(oc_high), .oc_low_i(oc_low), .ext_fault_i(ext_fault),
    .power_out_o(power_out_o), .sleep_o(sleep_o), .failsafe_o(failsafe_o),
    .watchdog_timeout_evt_o(watchdog_timeout_evt_o), .fault_flag_n_o(fault_flag_n_o),
    .fault_flag_oe_o(fault_flag_oe_o), .fault_id_o(fault_id_o));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(negedge clock_i) begin
    if (watchdog_timeout_evt_o === 1'b1) n_evt++;
  end
  always @(posedge clock_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task cyc(input int k);
    repeat (k) @(negedge clock_i);
  endtask : cyc
  task wait_evt;
    do begin
      cyc(1);
      n++;
    end while (watchdog_timeout_evt_o !== 1'b1 && n < 300);
  endtask : wait_evt
  task t_sleep;
    cyc(2);
    `CHK(sleep_o, 1'b1)
    `CHK(power_out_o, 1'b0)
    $display("test sleep done");
  endtask : t_sleep
  task t_direct;
    rst_req = 1'b1;
    cyc(2);
    `CHK(sleep_o, 1'b0)
    `CHK(power_out_o, 1'b1)
    direct_in_i = 1'b0;
    cyc(2);
    `CHK(power_out_o, 1'b0)
    din_sel = 1'b0;
    ser_cmd = 1'b1;
    cyc(120);
    `CHK(power_out_o, 1'b1)
    `CHK(n_evt, 0)
    ser_cmd = 1'b0;
    din_sel = 1'b1;
    rst_req = 1'b0;
    cyc(2);
    $display("test direct done");
  endtask : t_direct
  task t_wd;
    for (int i = 0; i < 4; i++) begin
      wd_sel = 2'(i);
      fs_on = wd_sel[0];
      wake_i = 1'b1;
      cyc(1);
      rst_req = 1'b1;
      n = 0;
      wait_evt();
      `CHK(n, WDC[i] + 1)
      `CHK(failsafe_o, 1'b1)
      cyc(1);
      `CHK(watchdog_timeout_evt_o, 1'b0)
      `CHK(power_out_o, fs_on)
      rst_req = 1'b0;
      wake_i = 1'b0;
      cyc(2);
      `CHK(failsafe_o, 1'b0)
      `CHK(power_out_o, 1'b0)
    end
    $display("test watchdog done");
  endtask : t_wd
  task t_freeze;
    wd_sel = 2'b01;
    wake_i = 1'b1;
    cyc(1);
    rst_req = 1'b1;
    cyc(10);
    ce = 1'b0;
    cyc(20);
    `CHK({failsafe_o, watchdog_timeout_evt_o, sleep_o}, 3'b000)
    ce = 1'b1;
    n = 30;
    wait_evt();
    `CHK(n, WDC[1] + 21)
    `CHK(failsafe_o, 1'b1)
    rst_req = 1'b0;
    wake_i = 1'b0;
    cyc(2);
    $display("test clock enable done");
  endtask : t_freeze
  task t_kick;
    wd_sel = 2'b01;
    wake_i = 1'b1;
    cyc(1);
    rst_req = 1'b1;
    cyc(30);
    kick = 1'b1;
    cyc(1);
    kick = 1'b0;
    n = 31;
    wait_evt();
    `CHK(n, WDC[1] + 31)
    rst_req = 1'b0;
    wake_i = 1'b0;
    cyc(2);
    $display("test kick done");
  endtask : t_kick
  task t_gnd;
    fs_gnd = 1'b1;
    wake_i = 1'b1;
    rst_req = 1'b1;
    n = n_evt;
    cyc(200);
    `CHK(n_evt - n, 0)
    `CHK(failsafe_o, 1'b0)
    rst_req = 1'b0;
    wake_i = 1'b0;
    fs_gnd = 1'b0;
    cyc(2);
    $display("test grounded select done");
  endtask : t_gnd
  task t_oc;
    ocl_sel = 2'b10;
    direct_in_i = 1'b1;
    rst_req = 1'b1;
    cyc(50);
    oc_low = 1'b1;
    cyc(1);
    oc_low = 1'b0;
    cyc(3);
    `CHK(fault_id_o, 6'h00)
    `CHK(fault_flag_n_o, 1'b1)
    oc_high = 1'b1;
    cyc(1);
    oc_high = 1'b0;
    cyc(3);
    `CHK(fault_id_o, 6'h01)
    `CHK({fault_flag_n_o, fault_flag_oe_o, power_out_o}, 3'b010)
    rst_req = 1'b0;
    cyc(3);
    `CHK(fault_id_o, 6'h00)
    `CHK(fault_flag_oe_o, 1'b0)
    rst_req = 1'b1;
    cyc(500);
    oc_low = 1'b1;
    cyc(1);
    oc_low = 1'b0;
    cyc(3);
    `CHK(fault_id_o, 6'h02)
    ext_fault = 4'h8;
    cyc(2);
    ext_fault = 4'h0;
    `CHK(fault_id_o, 6'h22)
    vdd_lost_i = 1'b1;
    cyc(2);
    vdd_lost_i = 1'b0;
    `CHK(fault_id_o, 6'h00)
    cyc(2);
    `CHK(fault_flag_n_o, 1'b1)
    $display("test over-current done");
  endtask : t_oc
  task final_report;
    $display("counts checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    {sys_rst_i, din_sel, direct_in_i} = 3'b111;
    ce = 1'b1;
    {supply_ok, rst_req, kick, wake_i, vdd_lost_i, fs_gnd, fs_on, ser_cmd, oc_high, oc_low} = '0;
    {wd_sel, ocl_sel, ext_fault} = '0;
    cyc(6);
    sys_rst_i = 1'b0;
    supply_ok = 1'b1;
    t_sleep();
    t_direct();
    t_wd();
    t_freeze();
    t_kick();
    t_gnd();
    t_oc();
    final_report();
  end
endmodule : testbench
